/* rtl/malf_reset_stretch.sv */
// Shared constants and types, and the malfunction reset stretcher
package rcs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFS_SYS_CTRL = 4'h0;
	localparam logic [3:0] OFS_WDT_CTRL = 4'h1;
	localparam logic [3:0] OFS_WU_CTRL = 4'h2;
	localparam logic [3:0] OFS_WU_CMP = 4'h3;
	localparam logic [3:0] OFS_IRQ_EN = 4'h4;
	localparam logic [3:0] OFS_IRQ_LAT = 4'h5;
	localparam logic [3:0] OFS_STATUS = 4'h6;
	localparam logic [3:0] OFS_PRESC = 4'h7;
	// system_control_two fields
	localparam int XEN_BIT = 7;
	localparam int XTEN_BIT = 6;
	localparam int SYSCK_BIT = 5;
	localparam logic [7:0] SYS_CTRL_RST = 8'h80;
	// watchdog_control_one fields
	localparam int TRAP_RAM_AREA_SELECT_BIT = 0;
	localparam int TRAP_OUTPUT_SELECT_BIT = 1;
	localparam int WDTOUT_BIT = 2;
	localparam int WDTEN_BIT = 3;
	localparam logic [7:0] WDT_CTRL_RST = 8'h0e;
	// warmup_timer_high_ctrl fields
	localparam logic [2:0] WU_MODE_WARMUP = 3'h5;
	localparam int WU_START_BIT = 3;
	localparam int WU_SRC_FAST_BIT = 6;
	// Interrupt enable and latch bits
	localparam int IRQ_MASTER_BIT = 0;
	localparam int IRQ_WU_EN_BIT = 1;
	localparam int LAT_TRAP_BIT = 0;
	localparam int LAT_WDT_BIT = 1;
	localparam int LAT_WU_BIT = 2;
	// Reset cause bits
	localparam int CAUSE_PIN_BIT = 0;
	localparam int CAUSE_TRAP_BIT = 1;
	localparam int CAUSE_WDT_BIT = 2;
	localparam int CAUSE_SYSCLK_BIT = 3;
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
	// Address map of the trap areas
	localparam logic [15:0] SFR_LO = 16'h0000;
	localparam logic [15:0] SFR_HI = 16'h003f;
	localparam logic [15:0] RAM_LO = 16'h0040;
	localparam logic [15:0] RAM_HI = 16'h083f;
	localparam logic [15:0] DBR_LO = 16'h0f80;
	localparam logic [15:0] DBR_HI = 16'h0fff;
	// Timing, in picoseconds and fast clock periods, and the derived cycle counts
	localparam int CLK_PERIOD_PS = 8000;
	localparam int FC_PERIOD_PS = 8000;
	localparam int MALF_STRETCH_FC = 24;
	localparam int PIN_MIN_LOW_FC = 12;
	localparam int MALF_STRETCH_CYC =
		(MALF_STRETCH_FC * FC_PERIOD_PS) / CLK_PERIOD_PS;
	localparam int PIN_MIN_LOW_CYC =
		(PIN_MIN_LOW_FC * FC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MALF_CNT_W = 5;
	localparam int PIN_CNT_W = 4;

	typedef enum logic [1:0] {
		CLK_FAST    = 2'b00,
		CLK_TO_SLOW = 2'b01,
		CLK_SLOW    = 2'b10,
		CLK_TO_FAST = 2'b11
	} clk_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	typedef struct packed {
		logic [MALF_CNT_W-1:0] cnt;
		logic                  active;
	} stretch_state_t;

	typedef struct packed {
		logic [7:0]           sys_ctrl;
		logic [7:0]           wdt_ctrl;
		logic [7:0]           wu_ctrl;
		logic [15:0]          wu_cmp;
		logic [15:0]          wu_cnt;
		logic [1:0]           irq_en;
		logic [2:0]           irq_lat;
		logic [3:0]           cause;
		logic [15:0]          presc;
		logic [PIN_CNT_W-1:0] pin_low_cnt;
		logic                 pin_reset;
		clk_state_t           clk_st;
		logic [DATA_W-1:0]    rdata;
	} rcs_state_t;
endpackage

`timescale 1ns/100ps
module malf_reset_stretch #(
	parameter int CYCLES = rcs_pkg::MALF_STRETCH_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic req_in,
	output logic      active_out
);
	rcs_pkg::stretch_state_t s_q;
	rcs_pkg::stretch_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (s_q.active)
		begin
			if (s_q.cnt == '0)
				s_d.active = 1'b0;
			else
				s_d.cnt = s_q.cnt - 1'b1;
		end
		else if (req_in)
		begin
			s_d.active = 1'b1;
			s_d.cnt = rcs_pkg::MALF_CNT_W'(CYCLES - 1);
		end
	end

	// Starts busy: one stretched pulse follows power-up
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			s_q <= '{cnt: rcs_pkg::MALF_CNT_W'(CYCLES - 1), active: 1'b1}; // RQ3
		else
			s_q <= s_d;
	end

	assign active_out = s_q.active;
endmodule

/* rtl/reset_and_clock_switch_control.sv */
// Reset merging, malfunction reset stretch and system clock switching
// What this block does
// [RQ1] Four reset sources: pin, address trap, watchdog, system clock.
// [RQ2] Malfunction reset lasts 24 fast periods, reset pin driven low.
// [RQ3] Stretcher not cleared at power-up; one pulse may follow.
// [RQ4] Pin must stay low twelve fast periods before reset applies.
// [RQ5] Pin high releases reset; execution starts at top vector.
// [RQ6] Reset clears master enable, source enables, request latches.
// [RQ7] Reset clears prescaler, enables watchdog, leaves core data alone.
// [RQ8] Fetch from special area, data buffer or selected RAM traps.
// [RQ9] Clearing both oscillator enables raises system clock reset.
// [RQ10] Stopping the oscillator in use raises system clock reset.
// [RQ11] Control two: bit 7 fast oscillator, bit 5 slow clock select.
// [RQ12] Software selects slow clock before stopping fast oscillator.
// [RQ13] Software waits fast oscillator warm-up before selecting it.
// [RQ14] Back to fast clock only once both clocks are in step.
// [RQ15] Pin reset leaves slow mode; restart in single clock mode.
// [RQ16] Warm-up counter mode 05h; expiry latches the warm-up request.
// [RQ17] One merged reset; stretcher runs apart from reset it makes.
// [RQ18] After reset trap and watchdog act as reset requests.
`timescale 1ns/100ps
module reset_and_clock_switch_control (
	input  wire logic                      clk_in,
	input  wire logic                      rst_b_in,
	input  wire logic [rcs_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [rcs_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                      reg_wr_in,
	input  wire logic                      reg_rd_in,
	output logic      [rcs_pkg::DATA_W-1:0] reg_rdata_out,
	input  wire logic                      reset_pin_in,
	output logic                           reset_pin_out,
	output logic                           reset_pin_oe_out,
	input  wire logic                      fetch_valid_in,
	input  wire logic [15:0]               fetch_addr_in,
	input  wire logic                      wdt_expire_in,
	input  wire logic                      lf_tick_in,
	output logic                           core_reset_out,
	output logic      [15:0]               reset_vector_addr_out,
	output logic                           hf_osc_en_out,
	output logic                           lf_osc_en_out,
	output logic                           run_on_low_clock_out,
	output logic                           watchdog_enable_out,
	output logic      [15:0]               prescaler_out,
	output logic                           irq_master_enable_out,
	output logic                           warmup_done_irq_out,
	output logic                           trap_irq_out,
	output logic                           wdt_irq_out
);
	logic [1:0]          rst_sync_q;
	logic                rst_b;
	rcs_pkg::bus_req_t   bus;
	rcs_pkg::rcs_state_t s_q;
	rcs_pkg::rcs_state_t s_d;
	logic                malf_active;
	logic                trap_hit;
	logic                trap_rst;
	logic                wdt_rst;
	logic                sysclk_rst;
	logic                malf_req;
	logic                wu_tick;
	logic                wu_hit;
	logic [7:0]          wsys;

	// Async assert, clocked release
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_b = rst_sync_q[1];

	assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in,
		wr: reg_wr_in, rd: reg_rd_in};
	assign wsys = bus.wdata[7:0];

	// Merged reset: held pin reset or stretched malfunction
	assign core_reset_out = s_q.pin_reset | malf_active; // RQ17

	assign trap_hit = fetch_valid_in & (
		(fetch_addr_in >= rcs_pkg::SFR_LO && fetch_addr_in <= rcs_pkg::SFR_HI)
		| (fetch_addr_in >= rcs_pkg::DBR_LO && fetch_addr_in <= rcs_pkg::DBR_HI)
		| (fetch_addr_in >= rcs_pkg::RAM_LO && fetch_addr_in <= rcs_pkg::RAM_HI
			&& s_q.wdt_ctrl[rcs_pkg::TRAP_RAM_AREA_SELECT_BIT])); // RQ8
	assign trap_rst = trap_hit & s_q.wdt_ctrl[rcs_pkg::TRAP_OUTPUT_SELECT_BIT]
		& ~core_reset_out; // RQ8
	assign wdt_rst = wdt_expire_in & s_q.wdt_ctrl[rcs_pkg::WDTOUT_BIT]
		& ~core_reset_out;
	// Judged on the written value; a rejected write is dropped
	assign sysclk_rst = bus.wr && bus.addr == rcs_pkg::OFS_SYS_CTRL
		&& !core_reset_out
		&& ((!wsys[rcs_pkg::XEN_BIT] && !wsys[rcs_pkg::XTEN_BIT]) // RQ9
		|| (!wsys[rcs_pkg::XEN_BIT] && !wsys[rcs_pkg::SYSCK_BIT]) // RQ10
		|| (!wsys[rcs_pkg::XTEN_BIT] && wsys[rcs_pkg::SYSCK_BIT])); // RQ10
	assign malf_req = trap_rst | wdt_rst | sysclk_rst; // RQ1

	assign wu_tick = s_q.wu_ctrl[rcs_pkg::WU_SRC_FAST_BIT] | lf_tick_in;
	assign wu_hit = s_q.wu_ctrl[2:0] == rcs_pkg::WU_MODE_WARMUP
		&& s_q.wu_ctrl[rcs_pkg::WU_START_BIT] && wu_tick
		&& s_q.wu_cnt == s_q.wu_cmp; // RQ16

	// Own counter and power reset only, so the pulse always completes
	malf_reset_stretch u_stretch (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b),
		.req_in     (malf_req),
		.active_out (malf_active)
	); // RQ17

	always_comb
	begin
		s_d = s_q;
		s_d.rdata = '0;
		// Pin low count; own drive during a stretch also counts
		if (!reset_pin_in)
		begin
			if (s_q.pin_low_cnt < rcs_pkg::PIN_CNT_W'(rcs_pkg::PIN_MIN_LOW_CYC))
				s_d.pin_low_cnt = s_q.pin_low_cnt + 1'b1;
			if (s_q.pin_low_cnt + 1'b1 >=
				rcs_pkg::PIN_CNT_W'(rcs_pkg::PIN_MIN_LOW_CYC))
				s_d.pin_reset = 1'b1; // RQ4
		end
		else
		begin
			s_d.pin_low_cnt = '0;
			s_d.pin_reset = 1'b0; // RQ5
		end
		if (core_reset_out)
		begin
			s_d.sys_ctrl = rcs_pkg::SYS_CTRL_RST; // RQ15
			s_d.clk_st = rcs_pkg::CLK_FAST; // RQ15
			s_d.wdt_ctrl = rcs_pkg::WDT_CTRL_RST; // RQ18
			s_d.irq_en = '0; // RQ6
			s_d.irq_lat = '0; // RQ6
			s_d.presc = '0; // RQ7
			s_d.wu_ctrl = '0;
			s_d.wu_cnt = '0;
			s_d.wu_cmp = '0;
			if (s_q.pin_reset)
				s_d.cause[rcs_pkg::CAUSE_PIN_BIT] = 1'b1;
		end
		else
		begin
			s_d.presc = s_q.presc + 1'b1;
			if (bus.wr)
			begin
				unique case (bus.addr)
					rcs_pkg::OFS_SYS_CTRL:
						if (!sysclk_rst)
							s_d.sys_ctrl = wsys & 8'he0; // RQ11
					rcs_pkg::OFS_WDT_CTRL: s_d.wdt_ctrl = wsys & 8'h0f;
					rcs_pkg::OFS_WU_CTRL:  s_d.wu_ctrl = wsys;
					rcs_pkg::OFS_WU_CMP:   s_d.wu_cmp = bus.wdata;
					rcs_pkg::OFS_IRQ_EN:   s_d.irq_en = bus.wdata[1:0];
					rcs_pkg::OFS_IRQ_LAT:
						s_d.irq_lat = s_q.irq_lat & bus.wdata[2:0];
					rcs_pkg::OFS_STATUS:
						s_d.cause = s_q.cause & ~bus.wdata[3:0];
					default: ;
				endcase
			end
			// Warm-up counter
			if (s_q.wu_ctrl[2:0] == rcs_pkg::WU_MODE_WARMUP
				&& s_q.wu_ctrl[rcs_pkg::WU_START_BIT])
			begin
				if (wu_hit)
					s_d.wu_cnt = '0;
				else if (wu_tick)
					s_d.wu_cnt = s_q.wu_cnt + 1'b1;
			end
			else
				s_d.wu_cnt = '0;
			// Latch sets win over a clearing write
			if (wu_hit)
				s_d.irq_lat[rcs_pkg::LAT_WU_BIT] = 1'b1; // RQ16
			if (trap_hit && !s_q.wdt_ctrl[rcs_pkg::TRAP_OUTPUT_SELECT_BIT])
				s_d.irq_lat[rcs_pkg::LAT_TRAP_BIT] = 1'b1;
			if (wdt_expire_in && !s_q.wdt_ctrl[rcs_pkg::WDTOUT_BIT])
				s_d.irq_lat[rcs_pkg::LAT_WDT_BIT] = 1'b1;
			// Clock switch follows select, on slow clock edges
			unique case (s_q.clk_st)
				rcs_pkg::CLK_FAST:
					if (s_q.sys_ctrl[rcs_pkg::SYSCK_BIT])
						s_d.clk_st = rcs_pkg::CLK_TO_SLOW;
				rcs_pkg::CLK_TO_SLOW:
					if (lf_tick_in)
						s_d.clk_st = rcs_pkg::CLK_SLOW;
				rcs_pkg::CLK_SLOW:
					if (!s_q.sys_ctrl[rcs_pkg::SYSCK_BIT])
						s_d.clk_st = rcs_pkg::CLK_TO_FAST;
				rcs_pkg::CLK_TO_FAST:
					if (s_q.sys_ctrl[rcs_pkg::SYSCK_BIT])
						s_d.clk_st = rcs_pkg::CLK_SLOW;
					else if (lf_tick_in)
						s_d.clk_st = rcs_pkg::CLK_FAST; // RQ14
			endcase
		end
		// Cause bits survive the reset they record
		if (trap_rst)
			s_d.cause[rcs_pkg::CAUSE_TRAP_BIT] = 1'b1;
		if (wdt_rst)
			s_d.cause[rcs_pkg::CAUSE_WDT_BIT] = 1'b1;
		if (sysclk_rst)
			s_d.cause[rcs_pkg::CAUSE_SYSCLK_BIT] = 1'b1;
		if (bus.rd)
		begin
			unique case (bus.addr)
				rcs_pkg::OFS_SYS_CTRL: s_d.rdata = {8'h00, s_q.sys_ctrl};
				rcs_pkg::OFS_WDT_CTRL: s_d.rdata = {8'h00, s_q.wdt_ctrl};
				rcs_pkg::OFS_WU_CTRL:  s_d.rdata = {8'h00, s_q.wu_ctrl};
				rcs_pkg::OFS_WU_CMP:   s_d.rdata = s_q.wu_cmp;
				rcs_pkg::OFS_IRQ_EN:   s_d.rdata = {14'h0, s_q.irq_en};
				rcs_pkg::OFS_IRQ_LAT:  s_d.rdata = {13'h0, s_q.irq_lat};
				rcs_pkg::OFS_STATUS:
					s_d.rdata = {10'h0, s_q.clk_st, s_q.cause};
				rcs_pkg::OFS_PRESC:    s_d.rdata = s_q.presc;
				default:               s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q <= '0;
			s_q.sys_ctrl <= rcs_pkg::SYS_CTRL_RST;
			s_q.wdt_ctrl <= rcs_pkg::WDT_CTRL_RST;
			s_q.clk_st <= rcs_pkg::CLK_FAST;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata_out = s_q.rdata;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_out = malf_active; // RQ2
	assign reset_vector_addr_out = rcs_pkg::RESET_VECTOR_ADDR; // RQ5
	assign hf_osc_en_out = s_q.sys_ctrl[rcs_pkg::XEN_BIT];
	assign lf_osc_en_out = s_q.sys_ctrl[rcs_pkg::XTEN_BIT];
	assign run_on_low_clock_out = s_q.clk_st[1];
	assign watchdog_enable_out = s_q.wdt_ctrl[rcs_pkg::WDTEN_BIT]; // RQ7
	assign prescaler_out = s_q.presc;
	assign irq_master_enable_out = s_q.irq_en[rcs_pkg::IRQ_MASTER_BIT];
	assign warmup_done_irq_out = s_q.irq_lat[rcs_pkg::LAT_WU_BIT]
		& s_q.irq_en[rcs_pkg::IRQ_WU_EN_BIT]
		& s_q.irq_en[rcs_pkg::IRQ_MASTER_BIT];
	assign trap_irq_out = s_q.irq_lat[rcs_pkg::LAT_TRAP_BIT];
	assign wdt_irq_out = s_q.irq_lat[rcs_pkg::LAT_WDT_BIT];

	// Checks
	property p_malf_pin;
		@(posedge clk_in) disable iff (!rst_b)
		malf_req |=> reset_pin_oe_out && core_reset_out;
	endproperty
	a_malf_pin: assert property (p_malf_pin) // RQ2
		else $error("malfunction did not drive reset pin");

	property p_stretch_len;
		@(posedge clk_in) disable iff (!rst_b)
		$rose(reset_pin_oe_out) |-> reset_pin_oe_out[*8]
			##1 reset_pin_oe_out[*8] ##1 reset_pin_oe_out[*8]
			##1 !reset_pin_oe_out;
	endproperty
	a_stretch_len: assert property (p_stretch_len) // RQ2
		else $error("malfunction reset not 24 cycles");

	property p_pin_min;
		@(posedge clk_in) disable iff (!rst_b)
		s_q.pin_reset |-> s_q.pin_low_cnt
			== rcs_pkg::PIN_CNT_W'(rcs_pkg::PIN_MIN_LOW_CYC);
	endproperty
	a_pin_min: assert property (p_pin_min) // RQ4
		else $error("pin reset before minimum low time");

	property p_pin_release;
		@(posedge clk_in) disable iff (!rst_b)
		reset_pin_in |=> !s_q.pin_reset;
	endproperty
	a_pin_release: assert property (p_pin_release) // RQ5
		else $error("pin reset held after pin went high");

	property p_irq_clear;
		@(posedge clk_in) disable iff (!rst_b)
		core_reset_out |=> s_q.irq_en == '0 && s_q.irq_lat == '0
			&& !irq_master_enable_out;
	endproperty
	a_irq_clear: assert property (p_irq_clear) // RQ6
		else $error("interrupt state not cleared by reset");

	property p_presc_clear;
		@(posedge clk_in) disable iff (!rst_b)
		core_reset_out |=> prescaler_out == '0 && watchdog_enable_out;
	endproperty
	a_presc_clear: assert property (p_presc_clear) // RQ7
		else $error("prescaler or watchdog not reset");

	property p_trap;
		@(posedge clk_in) disable iff (!rst_b)
		fetch_valid_in && fetch_addr_in <= rcs_pkg::SFR_HI
			&& s_q.wdt_ctrl[rcs_pkg::TRAP_OUTPUT_SELECT_BIT] && !core_reset_out
			|=> reset_pin_oe_out;
	endproperty
	a_trap: assert property (p_trap) // RQ8
		else $error("fetch from special area did not reset");

	property p_both_osc_off;
		@(posedge clk_in) disable iff (!rst_b)
		reg_wr_in && reg_addr_in == rcs_pkg::OFS_SYS_CTRL
			&& !reg_wdata_in[rcs_pkg::XEN_BIT]
			&& !reg_wdata_in[rcs_pkg::XTEN_BIT] && !core_reset_out
			|=> reset_pin_oe_out && $stable(hf_osc_en_out);
	endproperty
	a_both_osc_off: assert property (p_both_osc_off) // RQ9
		else $error("stopping both oscillators did not reset");

	property p_to_fast_wait;
		@(posedge clk_in) disable iff (!rst_b)
		s_q.clk_st == rcs_pkg::CLK_TO_FAST && !lf_tick_in && !core_reset_out
			|=> run_on_low_clock_out;
	endproperty
	a_to_fast_wait: assert property (p_to_fast_wait) // RQ14
		else $error("left slow clock before synchronisation");

	property p_reset_mode;
		@(posedge clk_in) disable iff (!rst_b)
		core_reset_out |=> !run_on_low_clock_out && hf_osc_en_out
			&& s_q.wdt_ctrl[rcs_pkg::TRAP_OUTPUT_SELECT_BIT]
			&& s_q.wdt_ctrl[rcs_pkg::WDTOUT_BIT];
	endproperty
	a_reset_mode: assert property (p_reset_mode) // RQ15
		else $error("reset did not restore single clock mode");

	property p_warmup;
		@(posedge clk_in) disable iff (!rst_b)
		wu_hit && !core_reset_out |=> s_q.irq_lat[rcs_pkg::LAT_WU_BIT]
			##1 s_q.wu_cnt <= 16'h0001;
	endproperty
	a_warmup: assert property (p_warmup) // RQ16
		else $error("warm-up expiry not latched");

	c_trap_reset: cover property (@(posedge clk_in) disable iff (!rst_b)
		trap_rst ##1 reset_pin_oe_out);
	c_slow_fast: cover property (@(posedge clk_in) disable iff (!rst_b)
		s_q.clk_st == rcs_pkg::CLK_TO_FAST ##1
		s_q.clk_st == rcs_pkg::CLK_FAST);
	c_pin_reset: cover property (@(posedge clk_in) disable iff (!rst_b)
		$rose(s_q.pin_reset));
	c_warmup: cover property (@(posedge clk_in) disable iff (!rst_b)
		wu_hit);
endmodule

/* verification/reset_pin_model.sv */
// External reset circuitry model: pull-up, timed low pulses, wired pin
`timescale 1ns/100ps
module reset_pin_model (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic [7:0] hold_in,
	input  wire logic       dev_pin_in,
	input  wire logic       dev_oe_in,
	output logic            pin_out
);
	logic [7:0] low_cnt_q = 8'h00;

	// Holds the pin low for exactly the commanded count
	always_ff @(posedge clk_in)
	begin
		if (go_in)
			low_cnt_q <= hold_in;
		else if (low_cnt_q != 8'h00)
			low_cnt_q <= low_cnt_q - 8'h01;
	end

	// Pull-up wins only while no party pulls low
	assign pin_out = (low_cnt_q == 8'h00)
		&& !(dev_oe_in && !dev_pin_in);
endmodule

/* verification/tb_reset_and_clock_switch_control.sv */
// Self-checking bench for reset merging and clock switching
`timescale 1ns/100ps
module tb_reset_and_clock_switch_control;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd_s = 1'b0;
	logic        fv = 1'b0;
	logic [15:0] fa = 16'h0000;
	logic        wdt = 1'b0;
	logic        lf = 1'b0;
	logic        go = 1'b0;
	logic [7:0]  len = 8'h00;
	logic [15:0] rdata, vec, presc, d;
	logic        pin, pin_o, oe, core_rst, hf_en, lf_en, slow;
	logic        wd_en, irq_master_enable, wu_irq, trap_irq, wdt_irq, seen;
	int          n_fail = 0;
	int          n_tests = 0;
	int          w, k, i;
	logic [15:0] taddr [8] = '{16'h0000, 16'h003f, 16'h0040, 16'h083f,
		16'h0f80, 16'h0fff, 16'h0840, 16'h1000};
	logic [15:0] cw [5][3] = '{'{16'hc0, 16'h40, 1}, '{16'hc0, 16'h00, 1},
		'{16'he0, 16'ha0, 1}, '{16'h80, 16'h00, 1}, '{16'hc0, 16'h80, 0}};

	reset_and_clock_switch_control dut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .reset_pin_in(pin), .reset_pin_out(pin_o),
		.reset_pin_oe_out(oe), .fetch_valid_in(fv), .fetch_addr_in(fa),
		.wdt_expire_in(wdt), .lf_tick_in(lf), .core_reset_out(core_rst),
		.reset_vector_addr_out(vec), .hf_osc_en_out(hf_en),
		.lf_osc_en_out(lf_en), .run_on_low_clock_out(slow),
		.watchdog_enable_out(wd_en), .prescaler_out(presc),
		.irq_master_enable_out(irq_master_enable), .warmup_done_irq_out(wu_irq),
		.trap_irq_out(trap_irq), .wdt_irq_out(wdt_irq));

	reset_pin_model partner (
		.clk_in(clk_in), .go_in(go), .hold_in(len), .dev_pin_in(pin_o),
		.dev_oe_in(oe), .pin_out(pin));

	initial
	begin
		forever #4 clk_in = ~clk_in;
	end

	task automatic close_out;
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		// Let the written value settle before anyone looks at it
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rreg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic pulse(input logic f, input logic [15:0] a);
		@(posedge clk_in);
		fa <= a;
		fv <= f;
		wdt <= !f;
		@(posedge clk_in);
		fv <= 1'b0;
		wdt <= 1'b0;
	endtask

	task automatic tick;
		@(posedge clk_in);
		lf <= 1'b1;
		@(posedge clk_in);
		lf <= 1'b0;
	endtask

	task automatic settle;
		int c;
		c = 0;
		while (core_rst !== 1'b0 && c < 200)
		begin
			@(posedge clk_in);
			#1;
			c++;
		end
		check(c < 200, "reset never ends");
		repeat (2) @(posedge clk_in);
	endtask

	// Width of the device's own pin drive after a trigger
	task automatic measure(output int v);
		int c;
		v = 0;
		c = 0;
		#1;
		while (oe !== 1'b1 && c < 3)
		begin
			@(posedge clk_in);
			#1;
			c++;
		end
		while (oe === 1'b1 && v < 99)
		begin
			v++;
			@(posedge clk_in);
			#1;
		end
		settle();
	endtask

	task automatic pin_pulse(input logic [7:0] n, output logic s);
		@(posedge clk_in);
		len <= n;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		s = 1'b0;
		repeat (int'(n) + 3)
		begin
			@(posedge clk_in);
			#1;
			if (core_rst === 1'b1)
				s = 1'b1;
		end
		settle();
	endtask

	function automatic logic trap_exp(input logic [15:0] a, input logic r);
		return a <= rcs_pkg::SFR_HI
			|| (a >= rcs_pkg::DBR_LO && a <= rcs_pkg::DBR_HI)
			|| (r && a >= rcs_pkg::RAM_LO && a <= rcs_pkg::RAM_HI);
	endfunction

	initial
	begin
		repeat (30000) @(posedge clk_in);
		n_fail++;
		close_out();
	end

	initial
	begin
		void'($urandom(85));
		repeat (16) @(posedge clk_in);
		rst_b_in <= 1'b1;
		measure(w);
		check(w > 0 && w <= 30, "power-up stretch");
		check(presc < 16'h0008, "prescaler not cleared");
		check(wd_en === 1'b1 && irq_master_enable === 1'b0, "core state");
		check(vec === 16'hfffe, "vector");
		rreg(rcs_pkg::OFS_SYS_CTRL, d);
		check(d === 16'h0080, "sys ctrl reset");
		rreg(rcs_pkg::OFS_WDT_CTRL, d);
		check(d === 16'h000e, "wdt ctrl reset");
		rreg(rcs_pkg::OFS_IRQ_LAT, d);
		check(d === 16'h0000, "latches reset");
		rreg(4'hf, d);
		check(d === 16'h0000, "unmapped read");
		for (i = 0; i < 8; i++)
		begin
			wreg(rcs_pkg::OFS_IRQ_EN, 16'h0003);
			check(irq_master_enable === 1'b1, "enable write lost");
			len = (i < 2) ? 8'(11 + i) : 8'($urandom_range(30, 1));
			pin_pulse(len, seen);
			check(seen === (len >= 8'd12), "pin reset length");
			if (len >= 8'd12)
				check(irq_master_enable === 1'b0, "enable kept");
		end
		for (i = 0; i < 12; i++)
		begin
			fa = (i < 8) ? taddr[i] : 16'($urandom_range(16'h1fff, 0));
			wreg(rcs_pkg::OFS_WDT_CTRL, {15'h7, i[0]});
			pulse(1'b1, fa);
			measure(w);
			check(w === (trap_exp(fa, i[0]) ? 24 : 0), "trap");
		end
		pulse(1'b0, 16'h0000);
		measure(w);
		check(w === 24, "watchdog reset");
		rreg(rcs_pkg::OFS_STATUS, d);
		check(d[rcs_pkg::CAUSE_WDT_BIT] === 1'b1, "cause");
		wreg(rcs_pkg::OFS_WDT_CTRL, 16'h0008);
		pulse(1'b0, 16'h0000);
		pulse(1'b1, 16'h0000);
		measure(w);
		check(w === 0 && wdt_irq === 1'b1 && trap_irq === 1'b1, "irq");
		pin_pulse(8'd16, seen);
		check(trap_irq === 1'b0 && wdt_irq === 1'b0, "latch kept");
		for (i = 0; i < 5; i++)
		begin
			wreg(rcs_pkg::OFS_SYS_CTRL, cw[i][0]);
			wreg(rcs_pkg::OFS_SYS_CTRL, cw[i][1]);
			measure(w);
			check(w === (cw[i][2][0] ? 24 : 0), "clock reset");
		end
		wreg(rcs_pkg::OFS_SYS_CTRL, 16'h00e0);
		tick();
		tick();
		check(slow === 1'b1, "slow select");
		wreg(rcs_pkg::OFS_SYS_CTRL, 16'h0060);
		measure(w);
		check(w === 0 && hf_en === 1'b0 && lf_en === 1'b1, "osc");
		wreg(rcs_pkg::OFS_SYS_CTRL, 16'h00e0);
		wreg(rcs_pkg::OFS_WU_CMP, 16'd20);
		wreg(rcs_pkg::OFS_IRQ_EN, 16'h0003);
		wreg(rcs_pkg::OFS_WU_CTRL, 16'h004d);
		k = 0;
		while (wu_irq !== 1'b1 && k < 100)
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		check(k >= 20 && k <= 24, "warm-up time");
		wreg(rcs_pkg::OFS_SYS_CTRL, 16'h00c0);
		repeat (5) @(posedge clk_in);
		check(slow === 1'b1, "switched early");
		tick();
		repeat (3) @(posedge clk_in);
		check(slow === 1'b0, "no switch back");
		wreg(rcs_pkg::OFS_SYS_CTRL, 16'h00e0);
		tick();
		tick();
		pin_pulse(8'd20, seen);
		rreg(rcs_pkg::OFS_SYS_CTRL, d);
		check(slow === 1'b0 && d === 16'h0080, "mode after pin");
		close_out();
	end
endmodule
